// ==== sic_ctrl.sv ====
// sic_ctrl: serial interface control with shift register, 4-bit counter,
// wire modes, clock source selection and interrupt flags.
// assumes a classic wishbone master on clk_i; pins are asynchronous.
// How it works
// - start enable lets start flag interrupt
// - overflow enable lets overflow flag interrupt
// - wire mode changes outputs and the start detector only
// - mode 00 leaves outputs to the port register, no hold, no detector
// - three-wire: shift output overrides port bit
// - two-wire data pulls low on zero
// - two-wire clock held low after start
// - two-wire disables pull-ups on both pins
// - mode 11 also holds clock on overflow
// - external clock latches output opposite edge
// - select 00 strobe, 01 timer match
// - external edge shifts, counter both edges
// - strobe shifts once, reads zero
// - toggle bit clocks counter when selected
// - toggle inverts clock port, reads zero
// - overflow flag set on 15 to 0
// - start flag cleared by one, releases hold
// - output from shift register bit seven
`timescale 1ns/1ps
`default_nettype none
module sic_ctrl (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // timer compare match, same clock domain
  input  wire logic        timer_match_i,
  // global interrupt enable and interrupt
  input  wire logic        global_irq_en_i,
  output logic             irq_o,
  // data output pin
  output logic             do_o,
  output logic             do_oe_o,
  output logic             do_pull_o,
  // data input / sda pin
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  output logic             sda_pull_o,
  // clock / scl pin
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe_o,
  output logic             scl_pull_o
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] ctrl_r;
  logic [7:0] data_r;
  logic [7:0] port_r;
  logic [3:0] cnt_r;
  logic       sif_r;
  logic       oif_r;
  logic [1:0] imask_r;
  logic       latch_r;
  logic       sda_s;
  logic       scl_s;
  logic       sda_d_r;
  logic       scl_d_r;
  logic       ack_r;

  // both pin inputs pass two flops before any logic reads them
  sic_sync #(.W(2)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .d_i   ({sda_i, scl_i}),
    .q_o   ({sda_s, scl_s})
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // pins idle high; a low reset value would fake an edge on release
      sda_d_r <= 1'b1;
      scl_d_r <= 1'b1;
    end else if (ce_i) begin
      sda_d_r <= sda_s;
      scl_d_r <= scl_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  logic       req;
  logic       wr;
  logic [7:0] wbyte;
  logic       wr_ctrl;
  logic       wr_stat;
  logic       wr_data;
  logic       wr_port;
  logic       wr_mask;

  // the answer gates the request, so a held request is not written twice
  assign req     = cyc_i & stb_i & ~ack_r;
  assign wr      = req & we_i & sel_i[0] & ce_i;
  assign wbyte   = dat_i[7:0];
  assign wr_ctrl = wr & (adr_i == sic_pkg::ADDR_CTRL);
  assign wr_stat = wr & (adr_i == sic_pkg::ADDR_STATUS);
  assign wr_data = wr & (adr_i == sic_pkg::ADDR_DATA);
  assign wr_port = wr & (adr_i == sic_pkg::ADDR_PORT);
  assign wr_mask = wr & (adr_i == sic_pkg::ADDR_IMASK);

  // one wait-free answer: ack one cycle after the request is seen
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else if (ce_i) begin
      ack_r <= req;
    end
  end
  assign ack_o = ack_r;

  ////////////////////////////////////////////////////////////////////////////
  // mode and clock source
  sic_pkg::sic_wm_t wm;
  logic [1:0] cs;
  logic       clk_sel;
  logic       two_wire;
  logic       strobe;
  logic       toggle;

  assign wm       = sic_pkg::sic_wm_t'(ctrl_r[sic_pkg::CTRL_WM +: 2]);
  assign cs       = ctrl_r[sic_pkg::CTRL_CS +: 2];
  assign clk_sel  = ctrl_r[sic_pkg::CTRL_CLK];
  assign two_wire = wm[1];
  // a strobe acts under the clock source in force before its own write
  assign strobe   = wr_ctrl & wbyte[sic_pkg::CTRL_CLK];
  assign toggle   = wr_ctrl & wbyte[sic_pkg::CTRL_TC];

  // inputs keep their function in every wire mode
  logic pos_edge;
  logic neg_edge;
  logic shift_clk;
  logic cnt_clk;
  assign pos_edge = scl_s & ~scl_d_r;
  assign neg_edge = ~scl_s & scl_d_r;

  always_comb begin
    shift_clk = 1'b0;
    cnt_clk   = 1'b0;
    unique case (cs)
      2'h0: begin
        shift_clk = strobe;
        cnt_clk   = strobe;
      end
      2'h1: begin
        // a match is a one-clock pulse from this domain, no edge detect
        shift_clk = timer_match_i;
        cnt_clk   = timer_match_i;
      end
      2'h2, 2'h3: begin
        shift_clk = cs[0] ? neg_edge : pos_edge;
        cnt_clk   = clk_sel ? toggle : (pos_edge | neg_edge);
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register; the toggle bit is never stored, the strobe bit only as the select bit
  // the select bit sticks only while an external source is chosen
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= sic_pkg::CTRL_RST;
    end else if (ce_i && wr_ctrl) begin
      ctrl_r <= {wbyte[7:2], wbyte[sic_pkg::CTRL_CLK] & wbyte[3], 1'b0};
    end
  end

  // a set mask bit hides its flag from the interrupt only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      imask_r <= sic_pkg::IMASK_RST;
    end else if (ce_i && wr_mask) begin
      imask_r <= wbyte[1:0];
    end
  end

  // port register; toggle inverts clock port regardless of direction
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_r <= sic_pkg::PORT_RST;
    end else if (ce_i) begin
      if (wr_port) begin
        port_r <= wbyte;
      end else if (toggle) begin
        port_r[sic_pkg::PORT_CK_OUT] <= ~port_r[sic_pkg::PORT_CK_OUT];
      end
    end
  end

  // shift register: left shift, sampled input is the one-cycle-old pin
  logic data_in;
  assign data_in = sda_d_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_r <= sic_pkg::DATA_RST;
    end else if (ce_i) begin
      if (wr_data) begin
        data_r <= wbyte; // a write wins over a shift
      end else if (shift_clk) begin
        data_r <= {data_r[6:0], data_in};
      end
    end
  end

  // output latch: transparent with internal clock, opposite edge otherwise
  logic ext_clk;
  logic lat_open;
  assign ext_clk  = cs[1];
  // the latch stays shut from the sampling edge to the opposite edge
  assign lat_open = ~ext_clk | (cs[0] ? scl_s : ~scl_s);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      latch_r <= 1'b0;
    end else if (ce_i && lat_open) begin
      latch_r <= data_r[7];
    end
  end
  logic ser_out;
  assign ser_out = lat_open ? data_r[7] : latch_r;

  // counter and overflow
  logic       ovf;
  logic       start_det;
  // overflow is the count that wraps from the top back to zero
  assign ovf       = cnt_clk & (cnt_r == sic_pkg::CNT_MAX);
  // start: data falls while the clock stays high
  assign start_det = two_wire & scl_s & scl_d_r & ~sda_s & sda_d_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= 4'h0;
    end else if (ce_i) begin
      // a counter write beats a count in the same cycle
      if (wr_stat) begin
        cnt_r <= wbyte[sic_pkg::STAT_CNT +: 4];
      end else if (cnt_clk) begin
        cnt_r <= cnt_r + 4'h1;
      end
    end
  end

  // sticky flags: a set beats a clear in the same cycle, so no event is lost
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sif_r <= 1'b0;
    end else if (ce_i) begin
      if (start_det) begin
        sif_r <= 1'b1;
      end else if (wr_stat && wbyte[sic_pkg::STAT_SIF]) begin
        sif_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      oif_r <= 1'b0;
    end else if (ce_i) begin
      if (ovf) begin
        oif_r <= 1'b1;
      end else if (wr_stat && wbyte[sic_pkg::STAT_OIF]) begin
        oif_r <= 1'b0;
      end
    end
  end

  // interrupt: control enables, extra mask, and global enable
  logic sif_irq;
  logic oif_irq;
  assign sif_irq = sif_r & ctrl_r[sic_pkg::CTRL_SIE] & ~imask_r[1];
  assign oif_irq = oif_r & ctrl_r[sic_pkg::CTRL_OIE] & ~imask_r[0];
  assign irq_o   = global_irq_en_i & (sif_irq | oif_irq);

  ////////////////////////////////////////////////////////////////////////////
  // pin drive
  logic scl_hold;
  // the hold works through the clock driver, so it needs the direction bit
  assign scl_hold = two_wire & (sif_r |
                    ((wm == sic_pkg::SIC_WM_TWOH) & oif_r));

  always_comb begin
    do_o       = port_r[sic_pkg::PORT_DO_OUT];
    do_oe_o    = port_r[sic_pkg::PORT_DO_DIR];
    do_pull_o  = ~port_r[sic_pkg::PORT_DO_DIR] & port_r[sic_pkg::PORT_DO_OUT];
    sda_o      = port_r[sic_pkg::PORT_DI_OUT];
    sda_oe_o   = port_r[sic_pkg::PORT_DI_DIR];
    sda_pull_o = ~port_r[sic_pkg::PORT_DI_DIR] & port_r[sic_pkg::PORT_DI_OUT];
    scl_o      = port_r[sic_pkg::PORT_CK_OUT];
    scl_oe_o   = port_r[sic_pkg::PORT_CK_DIR];
    scl_pull_o = ~port_r[sic_pkg::PORT_CK_DIR] & port_r[sic_pkg::PORT_CK_OUT];
    unique case (wm)
      sic_pkg::SIC_WM_OFF: begin
        do_o = port_r[sic_pkg::PORT_DO_OUT];
      end
      sic_pkg::SIC_WM_THREE: begin
        do_o = ser_out;
      end
      sic_pkg::SIC_WM_TWO, sic_pkg::SIC_WM_TWOH: begin
        // open drain: the value stays low and the enable does the pulling
        sda_o      = 1'b0;
        sda_oe_o   = port_r[sic_pkg::PORT_DI_DIR] &
                     ~(ser_out & port_r[sic_pkg::PORT_DI_OUT]);
        sda_pull_o = 1'b0;
        scl_o      = 1'b0;
        scl_oe_o   = port_r[sic_pkg::PORT_CK_DIR] &
                     (~port_r[sic_pkg::PORT_CK_OUT] | scl_hold);
        scl_pull_o = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data
  // unmapped addresses read zero; strobe bits never read back
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0;
    end else if (ce_i && req) begin
      unique case (adr_i)
        sic_pkg::ADDR_CTRL:   dat_o <= {24'h0, ctrl_r[7:2], 2'h0};
        sic_pkg::ADDR_STATUS: dat_o <= {24'h0, sif_r, oif_r, 2'h0, cnt_r};
        sic_pkg::ADDR_DATA:   dat_o <= {24'h0, data_r};
        sic_pkg::ADDR_PORT:   dat_o <= {24'h0, port_r};
        sic_pkg::ADDR_IMASK:  dat_o <= {30'h0, imask_r};
        default:              dat_o <= 32'h0;
      endcase
    end
  end
endmodule : sic_ctrl
`default_nettype wire

// ==== sic_pkg.sv ====
// sic_pkg: register map, field positions and reset values of the serial
// interface control block.
// assumes a 32-bit classic wishbone slave with word-aligned registers.
package sic_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_DATA   = 8'h08;
  localparam logic [7:0] ADDR_PORT   = 8'h0C;
  localparam logic [7:0] ADDR_IMASK  = 8'h10;
  // control register fields
  localparam int CTRL_SIE = 7;
  localparam int CTRL_OIE = 6;
  localparam int CTRL_WM  = 4;
  localparam int CTRL_CS  = 2;
  localparam int CTRL_CLK = 1;
  localparam int CTRL_TC  = 0;
  // status register fields
  localparam int STAT_SIF = 7;
  localparam int STAT_OIF = 6;
  localparam int STAT_CNT = 0;
  // port register fields
  localparam int PORT_DO_OUT  = 0;
  localparam int PORT_DO_DIR  = 1;
  localparam int PORT_CK_OUT  = 2;
  localparam int PORT_CK_DIR  = 3;
  localparam int PORT_DI_OUT  = 4;
  localparam int PORT_DI_DIR  = 5;
  // reset values and counter top
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] PORT_RST = 8'h00;
  localparam logic [1:0] IMASK_RST = 2'h0;
  localparam logic [3:0] CNT_MAX = 4'hF;
  // wire modes
  typedef enum logic [1:0] {
    SIC_WM_OFF   = 2'h0,
    SIC_WM_THREE = 2'h1,
    SIC_WM_TWO   = 2'h2,
    SIC_WM_TWOH  = 2'h3
  } sic_wm_t;
  // one pin, four signals
  typedef struct packed {
    logic in;
    logic out;
    logic oe;
    logic pull;
  } sic_pin_t;
endpackage : sic_pkg

// ==== sic_sync.sv ====
// sic_sync: two flip-flop synchroniser for pin inputs.
// assumes inputs are asynchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
module sic_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  // data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // pulled-up pins idle high; resetting low would fake an edge
      meta_r <= '1;
      q_o    <= '1;
    end else if (ce_i) begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end
endmodule : sic_sync
`default_nettype wire

// ==== sic_ctrl_asserts.sv ====
// sic_ctrl_asserts: port-level checks of sic_ctrl, bound below.
// assumes one clock domain and a classic wishbone master.
`timescale 1ns/1ps
`default_nettype none
module sic_ctrl_asserts (
  // clock, reset and bus
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  // interrupt and pins
  input wire logic        global_irq_en_i,
  input wire logic        irq_o,
  input wire logic        sda_o,
  input wire logic        scl_o,
  input wire logic        sda_pull_o,
  input wire logic        scl_pull_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic       take;
  logic [1:0] wm_r;
  assign take = cyc_i & stb_i & ce_i & ~ack_o;
  // shadow of the wire mode, loaded on the edge the block takes it
  always_ff @(posedge clk_i) begin
    if (rst_i)
      wm_r <= 2'h0;
    else if (take & we_i & sel_i[0] & (adr_i == sic_pkg::ADDR_CTRL))
      wm_r <= dat_i[5:4];
  end
  ////////////////////////////////////////////////////////////////////////
  sequence s_req;
    take;
  endsequence
  sequence s_ans;
    ack_o ##1 !ack_o;
  endsequence
  property p_ack;
    s_req |=> s_ans;
  endproperty
  a_ack: assert property (p_ack) else $error("ack not a single pulse");
  property p_no_ack;
    !take |=> !ack_o;
  endproperty
  a_no_ack: assert property (p_no_ack) else $error("ack without request");
  property p_irq;
    !global_irq_en_i |-> !irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("irq while disabled");
  property p_pull;
    wm_r[1] |-> !sda_pull_o && !scl_pull_o;
  endproperty
  a_pull: assert property (p_pull) else $error("pull-up in two-wire");
  property p_sda;
    wm_r[1] |-> !sda_o;
  endproperty
  a_sda: assert property (p_sda) else $error("sda driven high");
  property p_scl;
    wm_r[1] |-> !scl_o;
  endproperty
  a_scl: assert property (p_scl) else $error("scl driven high");
  property p_strobe_rd;
    take && !we_i && (adr_i == sic_pkg::ADDR_CTRL) |=> dat_o[1:0] == 2'h0;
  endproperty
  a_strobe_rd: assert property (p_strobe_rd)
    else $error("strobe bits read back");
  property p_unmapped;
    take && !we_i && (adr_i == 8'h14) |=> dat_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
endmodule : sic_ctrl_asserts
bind sic_ctrl sic_ctrl_asserts u_asserts (.clk_i, .rst_i, .ce_i, .cyc_i,
  .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .global_irq_en_i,
  .irq_o, .sda_o, .scl_o, .sda_pull_o, .scl_pull_o);
`default_nettype wire

// ==== sic_peer.sv ====
// sic_peer: serial bus peer pulling sda and scl on an open-drain bus.
// assumes bus pull-ups, so a released line reads high.
`timescale 1ns/1ps
`default_nettype none
module sic_peer (
  // pulls, high while pulling the line low
  output logic sda_low_o,
  output logic scl_low_o
);
  initial begin
    sda_low_o = 1'b0;
    scl_low_o = 1'b0;
  end
  // data falls while the clock is high, then both let go in turn
  task automatic start_cond();
    #37 sda_low_o = 1'b1;
    #40 scl_low_o = 1'b1;
    #40 sda_low_o = 1'b0;
    #40 scl_low_o = 1'b0;
  endtask : start_cond
  // 80 ns clock; the line stands still between calls
  task automatic pulses(input int n);
    for (int i = 0; i < n; i++) begin
      #40 scl_low_o = 1'b1;
      #40 scl_low_o = 1'b0;
    end
  endtask : pulses
endmodule : sic_peer
`default_nettype wire

// ==== sic_ctrl_tb.sv ====
// sic_ctrl_tb: self-checking bench for sic_ctrl with a serial peer.
// assumes a pulled-up open-drain bus on sda and scl.
`timescale 1ns/1ps
`default_nettype none
module sic_ctrl_tb;
  logic        clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1;
  logic        cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic        timer_match_i = 1'b0, global_irq_en_i = 1'b0;
  logic [7:0]  adr_i = 8'h00;
  logic [3:0]  sel_i = 4'hF;
  logic [31:0] dat_i = 32'h0, dat_o, rnd = 32'h6F10;
  logic        ack_o, irq_o, do_o, do_oe_o, do_pull_o;
  logic        sda_o, sda_oe_o, sda_pull_o, scl_o, scl_oe_o, scl_pull_o;
  wire logic   sda_i, scl_i, p_sda, p_scl;
  int          n_mismatch = 0, check_count = 0, cycles = 0;
  int          m_cnt = 0, m_dat = 0, m_oif = 0, m_sif = 0;
  logic [7:0]  ext [3] = '{8'h08, 8'h0C, 8'h0A};
  int          ec [3] = '{4, 4, 0};
  assign sda_i = ~(p_sda | (sda_oe_o & ~sda_o));
  assign scl_i = ~(p_scl | (scl_oe_o & ~scl_o));
  sic_ctrl dut (.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .we_i, .adr_i,
    .sel_i, .dat_i, .dat_o, .ack_o, .timer_match_i, .global_irq_en_i,
    .irq_o, .do_o, .do_oe_o, .do_pull_o, .sda_i, .sda_o, .sda_oe_o,
    .sda_pull_o, .scl_i, .scl_o, .scl_oe_o, .scl_pull_o);
  sic_peer peer (.sda_low_o(p_sda), .scl_low_o(p_scl));
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 6000) begin
      n_mismatch++;
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  task automatic finish_test();
    if (n_mismatch == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                    output logic [7:0] q);
    int t;
    t = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
      t++;
    end while (ack_o !== 1'b1 && t < 20);
    q = dat_o[7:0];
    if (ack_o !== 1'b1) begin
      n_mismatch++;
      finish_test();
    end
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, a, d, q);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    wb(1'b0, a, 8'h00, q);
    chk(q, e);
  endtask : rdc
  function automatic logic [7:0] st();
    return {m_sif[0], m_oif[0], 2'h0, m_cnt[3:0]};
  endfunction : st
  // data in stays high, so ones shift in
  task automatic step(input int sh, input int ct);
    m_dat = ((m_dat << sh) | ((1 << sh) - 1)) & 255;
    m_cnt = m_cnt + ct;
    if (m_cnt > 15)
      m_oif = 1;
    m_cnt = m_cnt & 15;
  endtask : step
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    global_irq_en_i <= 1'b1;
    rdc(sic_pkg::ADDR_CTRL, sic_pkg::CTRL_RST);
    rdc(sic_pkg::ADDR_PORT, sic_pkg::PORT_RST);
    rdc(sic_pkg::ADDR_IMASK, {6'h0, sic_pkg::IMASK_RST});
    rdc(8'h14, 8'h00);
    rnd = xs(rnd);
    m_dat = rnd[7:0];
    wr(sic_pkg::ADDR_DATA, rnd[7:0]);
    wr(sic_pkg::ADDR_PORT, 8'h02);
    wr(sic_pkg::ADDR_STATUS, 8'h0E);
    m_cnt = 14;
    for (int i = 0; i < 3; i++) begin
      wr(sic_pkg::ADDR_CTRL, 8'h12);
      step(1, 1);
      chk({7'h0, do_o}, {7'h0, m_dat[7]});
    end
    chk({7'h0, do_oe_o}, 8'h01);
    rdc(sic_pkg::ADDR_STATUS, st());
    rdc(sic_pkg::ADDR_DATA, m_dat[7:0]);
    chk({7'h0, irq_o}, 8'h00);
    wr(sic_pkg::ADDR_CTRL, 8'h50);
    chk({7'h0, irq_o}, 8'h01);
    wr(sic_pkg::ADDR_IMASK, 8'h01);
    chk({7'h0, irq_o}, 8'h00);
    wr(sic_pkg::ADDR_IMASK, 8'h00);
    global_irq_en_i <= 1'b0;
    @(posedge clk_i);
    chk({7'h0, irq_o}, 8'h00);
    global_irq_en_i <= 1'b1;
    wr(sic_pkg::ADDR_STATUS, {4'h4, m_cnt[3:0]});
    m_oif = 0;
    chk({7'h0, irq_o}, 8'h00);
    wr(sic_pkg::ADDR_CTRL, 8'h04);
    // a match while the clock enable is low must leave all state alone
    ce_i <= 1'b0;
    timer_match_i <= 1'b1;
    @(posedge clk_i);
    ce_i <= 1'b1;
    timer_match_i <= 1'b0;
    @(posedge clk_i);
    repeat (3) begin
      timer_match_i <= 1'b1;
      @(posedge clk_i);
      timer_match_i <= 1'b0;
      @(posedge clk_i);
    end
    step(3, 3);
    rdc(sic_pkg::ADDR_STATUS, st());
    rdc(sic_pkg::ADDR_DATA, m_dat[7:0]);
    for (int i = 0; i < 3; i++) begin
      wr(sic_pkg::ADDR_CTRL, ext[i]);
      peer.pulses(2);
      repeat (8) @(posedge clk_i);
      step(2, ec[i]);
      rdc(sic_pkg::ADDR_STATUS, st());
      rdc(sic_pkg::ADDR_DATA, m_dat[7:0]);
    end
    wr(sic_pkg::ADDR_CTRL, 8'h0B);
    step(0, 1);
    rdc(sic_pkg::ADDR_STATUS, st());
    rdc(sic_pkg::ADDR_PORT, 8'h06);
    wr(sic_pkg::ADDR_PORT, 8'h0C);
    wr(sic_pkg::ADDR_CTRL, 8'hA0);
    peer.start_cond();
    repeat (8) @(posedge clk_i);
    m_sif = 1;
    chk({6'h0, scl_oe_o, irq_o}, 8'h03);
    rdc(sic_pkg::ADDR_STATUS, st());
    wr(sic_pkg::ADDR_STATUS, {4'h8, m_cnt[3:0]});
    m_sif = 0;
    chk({6'h0, scl_oe_o, irq_o}, 8'h00);
    wr(sic_pkg::ADDR_STATUS, 8'h0F);
    m_cnt = 15;
    wr(sic_pkg::ADDR_CTRL, 8'h32);
    chk({6'h0, scl_oe_o, irq_o}, 8'h02);
    step(1, 1);
    rdc(sic_pkg::ADDR_STATUS, st());
    wr(sic_pkg::ADDR_STATUS, 8'h40);
    m_oif = 0;
    m_cnt = 0;
    chk({7'h0, scl_oe_o}, 8'h00);
    wr(sic_pkg::ADDR_PORT, 8'h1C);
    chk({6'h0, sda_pull_o, sda_oe_o}, 8'h00);
    wr(sic_pkg::ADDR_PORT, 8'h3C);
    chk({7'h0, sda_oe_o}, {7'h0, ~m_dat[7]});
    wr(sic_pkg::ADDR_DATA, 8'h00);
    chk({7'h0, sda_oe_o}, 8'h01);
    finish_test();
  end
endmodule : sic_ctrl_tb
`default_nettype wire
